// ==== logic/cphs_pkg.sv ====
package cphs_pkg;
  // Two-bit handshake codes shared by both stage buses
  localparam logic [1:0] HS_ABSENT = 2'b10;
  localparam logic [1:0] HS_WAIT   = 2'b00;
  localparam logic [1:0] HS_GO     = 2'b01;
  localparam logic [1:0] HS_LAST   = 2'b11;

  localparam int DATA_W = 32;
  localparam int INSN_W = 32;

  // Execute cycle after which the privilege level follows a mode change
  localparam int MODE_LAG_PLAIN = 1;
  localparam int MODE_LAG_SRW   = 2;

  // Reset values
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // Instruction classes presented by the core sequencer
  typedef enum logic [1:0]
  {
    CPHS_OP_CTC,
    CPHS_OP_CTOC,
    CPHS_OP_CDP
  } cphs_op_t;
endpackage

// ==== logic/cphs_hs_if.sv ====
`timescale 1ns/1ps
// Handshake decode shared between the core sequencer and its helper
interface cphs_hs_if;
  import cphs_pkg::*;
  logic [1:0] code;
  logic       is_wait;
  logic       is_go;
  logic       is_last;
  logic       is_absent;
  modport src (input code, output is_wait, is_go, is_last, is_absent);
  modport dst (output code, input is_wait, is_go, is_last, is_absent);
endinterface

// ==== logic/cphs_hs_decode.sv ====
`timescale 1ns/1ps
// Classifies a handshake code into one-hot flags
module cphs_hs_decode
(
  cphs_hs_if.src hs
);
  import cphs_pkg::*;

  // Every code maps to exactly one flag
  always_comb
  begin
    hs.is_wait   = (hs.code == HS_WAIT);   // [RULE_01]
    hs.is_go     = (hs.code == HS_GO);
    hs.is_last   = (hs.code == HS_LAST);
    hs.is_absent = (hs.code == HS_ABSENT);
  end
endmodule

// ==== logic/cphs_core_port.sv ====
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Handshake codes: absent 10, wait 00, go 01, last 11.
// RULE_02: Strobe low means instruction bus updates next cycle; pipeline shifts.
// RULE_03: Coprocessor holds pipeline when stall is low at a clock edge.
// RULE_04: Unrecognised instruction gets absent on both handshake buses.
// RULE_05: Core pulses strobe low as instruction enters decode.
// RULE_06: On issue with passed condition, raise condition pass, sample decode bus.
// RULE_07: Later execute cycles sample execute bus; commit on last.
// RULE_08: Core to coprocessor transfer drives outbound data at commit.
// RULE_09: Inbound data sampled end of memory stage, written next cycle.
// RULE_10: Decode last on transfer: execute next cycle, ignore execute bus.
// RULE_11: Core interlocks by holding strobe high until data is ready.
// RULE_12: Coprocessor repeats decode response during interlock cycles.
// RULE_13: Data operation raises condition pass in execute phase two.
// RULE_14: Data operation: decode last, or decode wait then execute last.
// RULE_15: Data abort before: late cancel in phase after condition pass.
// RULE_16: Coprocessor bases privileged responses on user-mode indication.
// RULE_17: Mode update after execute cycle one, or two for status writes.
// RULE_18: Only the decode response at decode-to-execute move counts.
// RULE_19: Coprocessor stalls core with wait, repeated in execute as needed.
// RULE_20: Condition pass low abandons busy-wait on interrupt.
// RULE_21: After reset the coprocessor drives absent on both buses.
module cphs_core_port
(
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_clk_en,
  input  wire logic                      i_fetch,
  input  wire logic [cphs_pkg::INSN_W-1:0] i_fetch_insn,
  input  wire logic                      i_interlock,
  input  wire logic                      i_issue,
  input  wire logic                      i_cond_ok,
  input  wire cphs_pkg::cphs_op_t        i_op,
  input  wire logic [cphs_pkg::DATA_W-1:0] i_src_data,
  input  wire logic                      i_prev_abort,
  input  wire logic                      i_irq,
  input  wire logic                      i_mode_change,
  input  wire logic                      i_mode_srw,
  input  wire logic                      i_new_user,
  input  wire logic [1:0]                i_decode_handshake,
  input  wire logic [1:0]                i_execute_handshake,
  input  wire logic [cphs_pkg::DATA_W-1:0] i_coproc_to_core_data,
  output logic                           o_fetch_request_strobe_n,
  output logic [cphs_pkg::INSN_W-1:0]    o_instruction_follow_bus,
  output logic                           o_condition_pass,
  output logic                           o_late_cancel,
  output logic [cphs_pkg::DATA_W-1:0]    o_core_to_coproc_data,
  output logic                           o_user_mode_indication_n,
  output logic                           o_stall_n,
  output logic                           o_busy,
  output logic                           o_commit,
  output logic                           o_undef,
  output logic                           o_abandon,
  output logic                           o_wr_en,
  output logic [cphs_pkg::DATA_W-1:0]    o_wr_data
);
  import cphs_pkg::*;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_EXEC,
    ST_BUSY,
    ST_MEM,
    ST_WB
  } cphs_state_t;

  cphs_state_t state;
  cphs_op_t    op;
  logic [DATA_W-1:0] src;
  logic [DATA_W-1:0] rd_data;
  logic        mode_pend;
  logic        mode_srw;
  logic        mode_val;
  logic [1:0]  mode_cnt;

  cphs_hs_if de_if ();
  cphs_hs_if ex_if ();
  assign de_if.code = i_decode_handshake;
  assign ex_if.code = i_execute_handshake;

  cphs_hs_decode u_de
  (
    .hs (de_if)
  );
  cphs_hs_decode u_ex
  (
    .hs (ex_if)
  );

  // Fetch strobe and follower bus; interlock holds strobe high
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_fetch_request_strobe_n <= 1'b1;
      o_instruction_follow_bus <= DATA_RST;
      o_stall_n                <= 1'b1;
    end
    else if (i_clk_en)
    begin
      o_fetch_request_strobe_n <= !(i_fetch && !i_interlock); // [RULE_05] [RULE_11]
      if (i_fetch && !i_interlock)
        o_instruction_follow_bus <= i_fetch_insn;             // [RULE_02]
      o_stall_n <= 1'b1;
    end
  end

  // Execution sequencer: decode bus at issue, execute bus afterwards
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state            <= ST_IDLE;
      op               <= CPHS_OP_CDP;
      src              <= DATA_RST;
      o_condition_pass <= 1'b0;
      o_late_cancel    <= 1'b0;
      o_commit         <= 1'b0;
      o_undef          <= 1'b0;
      o_abandon        <= 1'b0;
      o_busy           <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_commit      <= 1'b0;
      o_undef       <= 1'b0;
      o_abandon     <= 1'b0;
      o_late_cancel <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          o_condition_pass <= 1'b0;
          // Decode response sampled only at the move into execute
          if (i_issue && i_cond_ok)                            // [RULE_18]
          begin
            o_condition_pass <= 1'b1;                          // [RULE_06] [RULE_13]
            op    <= i_op;
            src   <= i_src_data;
            state <= ST_EXEC;
            if (de_if.is_last)                                 // [RULE_10]
              state <= ST_EXEC;
            else if (de_if.is_absent)
            begin
              o_undef <= 1'b1;
              state   <= ST_IDLE;
            end
            else
            begin
              o_busy <= 1'b1;
              state  <= ST_BUSY;
            end
          end
        end
        ST_EXEC:
        begin
          // Late cancel in the cycle after condition pass
          o_late_cancel    <= i_prev_abort;                    // [RULE_15]
          o_condition_pass <= 1'b0;
          o_commit         <= !i_prev_abort;
          state <= (op == CPHS_OP_CTOC && !i_prev_abort) ? ST_MEM : ST_IDLE;
        end
        ST_BUSY:
        begin
          // Interrupt drops condition pass and abandons the instruction
          if (i_irq)
          begin
            o_condition_pass <= 1'b0;                          // [RULE_20]
            o_abandon        <= 1'b1;
            o_busy           <= 1'b0;
            state            <= ST_IDLE;
          end
          else if (ex_if.is_last)                              // [RULE_07]
          begin
            o_busy <= 1'b0;
            state  <= ST_EXEC;
          end
          else if (ex_if.is_absent)
          begin
            o_condition_pass <= 1'b0;
            o_undef          <= 1'b1;
            o_busy           <= 1'b0;
            state            <= ST_IDLE;
          end
        end
        ST_MEM:
          state <= ST_WB;
        ST_WB:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Outbound data is driven once a core-to-coprocessor (CTC) transfer commits
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_core_to_coproc_data <= DATA_RST;
    else if (i_clk_en && state == ST_EXEC && op == CPHS_OP_CTC
             && !i_prev_abort)
      o_core_to_coproc_data <= src;                            // [RULE_08]
  end

  // Inbound data captured at end of memory stage, written next cycle
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rd_data   <= DATA_RST;
      o_wr_en   <= 1'b0;
      o_wr_data <= DATA_RST;
    end
    else if (i_clk_en)
    begin
      o_wr_en <= 1'b0;
      if (state == ST_MEM)
        rd_data <= i_coproc_to_core_data;                      // [RULE_09]
      if (state == ST_WB)
      begin
        o_wr_en   <= 1'b1;
        o_wr_data <= rd_data;
      end
    end
  end

  // Privilege indication follows mode change after one or two exec cycles
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      mode_pend                <= 1'b0;
      mode_srw                 <= 1'b0;
      mode_val                 <= 1'b0;
      mode_cnt                 <= 2'd0;
      o_user_mode_indication_n <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (i_mode_change && !mode_pend)
      begin
        mode_pend <= 1'b1;
        mode_srw  <= i_mode_srw;
        mode_val  <= i_new_user;
        mode_cnt  <= 2'd1;
      end
      else if (mode_pend)
      begin
        if (mode_cnt >= (mode_srw ? 2'(MODE_LAG_SRW) : 2'(MODE_LAG_PLAIN)))
        begin
          o_user_mode_indication_n <= !mode_val;               // [RULE_17]
          mode_pend <= 1'b0;
        end
        else
          mode_cnt <= mode_cnt + 2'd1;
      end
    end
  end

  // Condition pass is never high in the memory or write-back stages
  a_pass_scope: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (state == ST_MEM || state == ST_WB) |-> !o_condition_pass) // [RULE_06]
    else $error("condition pass scope");
  // Interrupt in busy-wait drops condition pass next cycle
  a_irq_drop: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_clk_en && state == ST_BUSY && i_irq) |=> !o_condition_pass) // [RULE_20]
    else $error("pass not dropped on interrupt");
  // Late cancel only right after an execute cycle
  a_cancel_when: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_late_cancel |-> $past(state == ST_EXEC)) // [RULE_15]
    else $error("late cancel out of place");
  // Write-back two cycles after a read transfer commit
  a_wb_timing: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_clk_en && state == ST_MEM) ##1 i_clk_en |=> o_wr_en) // [RULE_09]
    else $error("write-back late");
  // Last on execute bus ends busy-wait
  a_busy_last: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_clk_en && state == ST_BUSY && !i_irq && ex_if.is_last)
    |=> state == ST_EXEC) // [RULE_07]
    else $error("last did not end busy-wait");
  // Interlock keeps strobe high
  a_interlock: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_clk_en && i_interlock) |=> o_fetch_request_strobe_n) // [RULE_11]
    else $error("strobe low during interlock");
  // Decode last issues straight into execute
  a_de_last: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_clk_en && state == ST_IDLE && i_issue && i_cond_ok && de_if.is_last)
    |=> state == ST_EXEC && o_condition_pass) // [RULE_10]
    else $error("decode last not executed");
  // Outbound data follows committed source
  a_out_data: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_clk_en && state == ST_EXEC && op == CPHS_OP_CTC && !i_prev_abort)
    |=> o_core_to_coproc_data == $past(src)) // [RULE_08]
    else $error("outbound data wrong");
endmodule

// ==== bench/cphs_coproc_model.sv ====
`timescale 1ns/1ps
// Coprocessor follower: instruction bits [1:0] kind, [7:4] waits, [8] priv
module cphs_coproc_model
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_strobe_n,
  input  wire logic [31:0] i_bus,
  input  wire logic        i_stall_n,
  input  wire logic        i_pass,
  input  wire logic        i_late_cancel,
  input  wire logic        i_user_n,
  output logic      [1:0]  o_decode_handshake,
  output logic      [1:0]  o_execute_handshake,
  output logic      [31:0] o_coproc_to_core_data
);
  import cphs_pkg::*;
  logic [31:0] dec_insn;
  logic [31:0] ex_insn;
  logic        dec_valid;
  logic        ex_valid;
  logic [3:0]  ex_cnt;
  logic [1:0]  dec_code;

  // Pipeline shifts on strobe low, frozen while stalled
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      dec_valid <= 1'b0;
      ex_valid  <= 1'b0;
      dec_insn  <= 32'h0000_0000;
      ex_insn   <= 32'h0000_0000;
      ex_cnt    <= 4'h0;
    end
    else if (i_stall_n)
    begin
      if (!i_strobe_n)
      begin
        dec_insn  <= i_bus;
        dec_valid <= 1'b1;
        ex_insn   <= dec_insn;
        ex_valid  <= dec_valid && dec_code != HS_ABSENT;
        ex_cnt    <= dec_insn[7:4];
      end
      else if (ex_valid)
      begin
        // No state kept after cancel or abandon
        if (i_late_cancel || !i_pass)
          ex_valid <= 1'b0;
        else if (ex_cnt != 4'h0)
          ex_cnt <= ex_cnt - 4'h1;
      end
    end
  end

  // Decode answer recomputed each cycle, so it tracks privilege changes
  always_comb
  begin
    if (!dec_valid || dec_insn[1:0] == 2'b00)
      dec_code = HS_ABSENT;
    else if (dec_insn[8] && !i_user_n)
      dec_code = HS_ABSENT;
    else if (dec_insn[1:0] == 2'b01)
      dec_code = HS_LAST;
    else
      dec_code = HS_WAIT;
  end

  // Both buses use the shared codes
  assign o_decode_handshake  = dec_code;
  assign o_execute_handshake = ex_valid ?
    ((ex_cnt != 4'h0) ? HS_WAIT : HS_LAST) :
    ((dec_code == HS_WAIT) ? HS_WAIT : HS_ABSENT);
  // Held from execute through memory stage
  assign o_coproc_to_core_data = ~ex_insn;
endmodule

// ==== bench/cphs_core_port_test.sv ====
`timescale 1ns/1ps
module cphs_core_port_test;
  import cphs_pkg::*;
  logic clk = 0, rst = 1, en = 1, fe = 0, il = 0, iss = 0, ok = 0;
  logic ab = 0, irq = 0, mc = 0, srw = 0, nu = 0;
  logic [31:0] fi = 0, src = 0, din, bus, dout, wd, s_wd;
  cphs_op_t op = CPHS_OP_CTC;
  logic [1:0] de, ex;
  logic sn, pass, lc, stn, un, bz, cm, ud, an, we;
  logic s_cm, s_ud, s_an, s_lc, s_bz, s_we, s_ps;
  int fail_count = 0, tests_run = 0, a, b;

  cphs_core_port i_cphs_core_port (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_clk_en(en), .i_fetch(fe), .i_fetch_insn(fi), .i_interlock(il),
    .i_issue(iss), .i_cond_ok(ok), .i_op(op), .i_src_data(src),
    .i_prev_abort(ab), .i_irq(irq), .i_mode_change(mc), .i_mode_srw(srw),
    .i_new_user(nu), .i_decode_handshake(de), .i_execute_handshake(ex),
    .i_coproc_to_core_data(din), .o_fetch_request_strobe_n(sn),
    .o_instruction_follow_bus(bus), .o_condition_pass(pass),
    .o_late_cancel(lc), .o_core_to_coproc_data(dout),
    .o_user_mode_indication_n(un), .o_stall_n(stn), .o_busy(bz),
    .o_commit(cm), .o_undef(ud), .o_abandon(an), .o_wr_en(we),
    .o_wr_data(wd));

  cphs_coproc_model i_cphs_coproc_model (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_strobe_n(sn), .i_bus(bus), .i_stall_n(stn), .i_pass(pass),
    .i_late_cancel(lc), .i_user_n(un), .o_decode_handshake(de),
    .o_execute_handshake(ex), .o_coproc_to_core_data(din));

  // 200 MHz clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task summarize;
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Fetch, let it reach decode, issue, then watch 40 cycles of pulses
  task run(input logic [31:0] w, input cphs_op_t o, input logic c,
           input int q);
    {s_cm, s_ud, s_an, s_lc, s_bz, s_we, s_ps} = 7'h00;
    s_wd = 32'h0000_0000;
    @(posedge clk) #1 fe = 1; fi = w; op = o; src = {w[15:0], w[31:16]};
    @(posedge clk) #1 fe = 0;
    repeat (2) @(posedge clk);
    #1 iss = 1; ok = 1; fe = 1; fi = 32'h0000_0000; ab = c;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk) #1 iss = 0; fe = 0; irq = (n == q);
      s_cm |= cm; s_ud |= ud; s_an |= an; s_lc |= lc; s_bz |= bz;
      s_we |= we;
      s_ps |= pass;
      if (we === 1'b1) s_wd = wd;
    end
    ab = 0; irq = 0; ok = 0;
  endtask

  // Pulse a mode change and count cycles until the indication follows
  task mode(input logic s, input logic u, output int n);
    @(posedge clk) #1 mc = 1; srw = s; nu = u;
    @(posedge clk) #1 mc = 0;
    n = 1;
    while (un !== !u && n < 8)
    begin
      @(posedge clk) #1 n++;
    end
  endtask

  task t_reset;
    check(sn, 1);
    check(stn, 1);
    check(pass, 0);
    check(de, HS_ABSENT);
  endtask

  task t_ctc;
    run(32'h0000_0001, CPHS_OP_CTC, 0, -1);
    check(s_cm, 1);
    check(s_bz, 0);
    check(s_ps, 1);
    check(dout, 32'h0001_0000);
  endtask

  task t_ctoc;
    run(32'h1234_5601, CPHS_OP_CTOC, 0, -1);
    check(s_we, 1);
    check(s_wd, 32'hEDCB_A9FE);
  endtask

  task t_cdp_busy;
    run(32'h0000_0032, CPHS_OP_CDP, 0, -1);
    check(s_bz, 1);
    check(s_cm, 1);
    check(s_ps, 1);
    check(pass, 0);
  endtask

  task t_cancel;
    run(32'h0000_0001, CPHS_OP_CDP, 1, -1);
    check(s_lc, 1);
    check(s_cm, 0);
  endtask

  task t_abandon;
    run(32'h0000_00F2, CPHS_OP_CDP, 0, 3);
    check(s_an, 1);
    check(s_cm, 0);
    check(pass, 0);
  endtask

  task t_absent;
    run(32'h0000_0000, CPHS_OP_CTC, 0, -1);
    check(s_ud, 1);
    check(s_cm, 0);
  endtask

  task t_lock;
    @(posedge clk) #1 il = 1; fe = 1; fi = 32'h0000_0001;
    repeat (3)
    begin
      @(posedge clk) #1 check(sn, 1);
    end
    il = 0;
    @(posedge clk) #1 fe = 0;
    check(sn, 0);
    check(bus, 32'h0000_0001);
  endtask

  // Reset leaves the indication low, so leave user mode first
  task t_priv;
    mode(0, 0, a);
    check(un, 1);
    check(a, MODE_LAG_PLAIN + 1);
    run(32'h0000_0101, CPHS_OP_CTC, 0, -1);
    check(s_cm, 1);
    mode(1, 1, b);
    check(un, 0);
    check(b - a, MODE_LAG_SRW - MODE_LAG_PLAIN);
    run(32'h0000_0101, CPHS_OP_CTC, 0, -1);
    check(s_ud, 1);
  endtask

  // Watchdog well past the expected few microseconds
  initial
  begin
    #50000;
    fail_count++;
    summarize();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst = 0;
    t_reset();
    t_ctc();
    t_ctoc();
    t_cdp_busy();
    t_cancel();
    t_abandon();
    t_absent();
    t_lock();
    t_priv();
    summarize();
  end
endmodule
